/* testbench/host_link_model.sv */
// host side of the serial link: shifts frames out msb first
`timescale 1ns/1ps
module host_link_model (
  // system clock, only used to pace the link
  input wire logic clock_i,
  // link pins
  output logic sclk_o,
  output logic frame_n_o,
  output logic data_o
);
  import dac_load_pkg::*;
  // 8 system cycles per half gives the 160 ns link period
  localparam int HALF = 8;

  initial begin
    sclk_o = 1'b0;
    frame_n_o = 1'b1;
    data_o = 1'b0;
  end

  task automatic half_wait();
    repeat (HALF) @(negedge clock_i);
  endtask

  // nbits other than 24 only where a short frame must be refused
  task automatic send_frame(input frame_t word, input int nbits);
    frame_n_o = 1'b0;
    half_wait();
    for (int i = 0; i < nbits; i++) begin
      data_o = word[FRAME_BITS-1-i];
      sclk_o = 1'b1;
      half_wait();
      sclk_o = 1'b0;
      half_wait();
    end
    frame_n_o = 1'b1;
    // released data line must not keep showing the last bit
    data_o = ~data_o;
    half_wait();
  endtask
endmodule // host_link_model

/* testbench/testbench.sv */
// self-checking bench for the serial load front end
`timescale 1ns/1ps
module testbench;
  import dac_load_pkg::*;
  localparam int LIMIT = 20000;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic sclk;
  logic frame_n;
  logic serial_in;
  logic load_output_n = 1'b0;
  logic clear_to_preset_n = 1'b1;
  logic reset_n = 1'b1;
  code_t preset_code = 20'h00000;
  logic twos_comp = 1'b0;
  code_t dac_code;
  code_t dac_drive;
  logic clamp;
  logic update_pending;
  logic buffer_full;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;

  always #5 clock = ~clock;

  host_link_model i_host_link_model (
    .clock_i(clock),
    .sclk_o(sclk),
    .frame_n_o(frame_n),
    .data_o(serial_in)
  );

  dac_serial_load_control i_dac_serial_load_control (
    .clock_i(clock),
    .resetn_i(resetn),
    .sclk_i(sclk),
    .frame_n_i(frame_n),
    .serial_in_i(serial_in),
    .load_output_n_i(load_output_n),
    .clear_to_preset_n_i(clear_to_preset_n),
    .reset_n_i(reset_n),
    .preset_code_i(preset_code),
    .twos_comp_i(twos_comp),
    .dac_code_o(dac_code),
    .dac_drive_o(dac_drive),
    .clamp_o(clamp),
    .update_pending_o(update_pending),
    .buffer_full_o(buffer_full)
  );

  task automatic check_code(input string what, input code_t exp, input code_t got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic test_power_up();
    check_code("dac_code", 20'h00000, dac_code);
    check_code("dac_drive", 20'h00000, dac_drive);
    check_bit("clamp", 1'b1, clamp);
    check_bit("update_pending", 1'b0, update_pending);
    check_bit("buffer_full", 1'b0, buffer_full);
    $display("test power_up done");
  endtask

  task automatic test_direct();
    i_host_link_model.send_frame(24'hA12345, 24);
    check_code("dac_code", 20'h12345, dac_code);
    check_code("dac_drive", 20'h12345, dac_drive);
    check_bit("clamp", 1'b0, clamp);
    twos_comp = 1'b1;
    i_host_link_model.send_frame(24'h0FFFFF, 24);
    check_code("dac_code", 20'hFFFFF, dac_code);
    check_code("dac_drive", 20'h7FFFF, dac_drive);
    $display("test direct done");
  endtask

  task automatic test_held();
    load_output_n = 1'b1;
    i_host_link_model.send_frame(24'h0ABCDE, 24);
    check_bit("update_pending", 1'b1, update_pending);
    check_code("dac_code", 20'hFFFFF, dac_code);
    i_host_link_model.send_frame(24'hFFFFFF, 23);
    check_code("dac_code", 20'hFFFFF, dac_code);
    load_output_n = 1'b0;
    settle(4);
    check_code("dac_code", 20'hABCDE, dac_code);
    check_code("dac_drive", 20'h2BCDE, dac_drive);
    check_bit("update_pending", 1'b0, update_pending);
    $display("test held done");
  endtask

  task automatic test_clear();
    load_output_n = 1'b1;
    i_host_link_model.send_frame(24'h011111, 24);
    preset_code = 20'h55AAA;
    clear_to_preset_n = 1'b0;
    settle(4);
    check_code("dac_code", 20'h55AAA, dac_code);
    check_code("dac_drive", 20'hD5AAA, dac_drive);
    check_bit("update_pending", 1'b0, update_pending);
    twos_comp = 1'b0;
    settle(4);
    check_code("dac_drive", 20'h55AAA, dac_drive);
    clear_to_preset_n = 1'b1;
    settle(2);
    load_output_n = 1'b0;
    settle(4);
    check_code("dac_code", 20'h55AAA, dac_code);
    $display("test clear done");
  endtask

  // clear stalls the drain, so the buffer fills while frames keep coming
  task automatic test_buffer();
    clear_to_preset_n = 1'b0;
    i_host_link_model.send_frame(24'h000001, 24);
    i_host_link_model.send_frame(24'h000002, 24);
    check_bit("buffer_full", 1'b1, buffer_full);
    i_host_link_model.send_frame(24'h000003, 24);
    i_host_link_model.send_frame(24'h000004, 24);
    clear_to_preset_n = 1'b1;
    settle(20);
    check_code("dac_code", 20'h00003, dac_code);
    check_bit("buffer_full", 1'b0, buffer_full);
    $display("test buffer done");
  endtask

  task automatic test_pin_reset();
    reset_n = 1'b0;
    settle(4);
    check_code("dac_code", 20'h00000, dac_code);
    check_bit("clamp", 1'b1, clamp);
    reset_n = 1'b1;
    settle(4);
    i_host_link_model.send_frame(24'h000777, 24);
    check_code("dac_code", 20'h00777, dac_code);
    check_bit("clamp", 1'b0, clamp);
    $display("test pin_reset done");
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_mismatch++;
      conclude();
    end
  end

  initial begin
    settle(12);
    resetn = 1'b1;
    settle(4);
    test_power_up();
    test_direct();
    test_held();
    test_clear();
    test_buffer();
    test_pin_reset();
    conclude();
  end
endmodule // testbench

/* verilog/dac_load_pkg.sv */
// shared constants, types and helpers for the serial load front end
package dac_load_pkg;

  localparam int FRAME_BITS = 24;
  localparam int CODE_BITS = 20;
  localparam int COUNT_BITS = 5;
  localparam int BUF_DEPTH = 2;
  localparam int SYNC_STAGES = 2;
  localparam logic [CODE_BITS-1:0] CODE_RESET = 20'h00000;
  localparam logic [CODE_BITS-1:0] CODE_MSB = 20'h80000;
  localparam logic [COUNT_BITS-1:0] COUNT_FULL = 5'h18;
  localparam logic [COUNT_BITS-1:0] COUNT_MAX = 5'h1F;

  typedef logic [CODE_BITS-1:0] code_t;
  typedef logic [FRAME_BITS-1:0] frame_t;

  // serial link pins after synchronisation
  typedef struct packed {
    logic sclk;
    logic frame_n;
    logic data;
  } link_pins_s;

  // asynchronous control pins after synchronisation
  typedef struct packed {
    logic load_output_n;
    logic clear_to_preset_n;
    logic reset_n;
  } ctrl_pins_s;

  typedef enum logic [0:0] {
    ST_CLAMPED = 1'b0,
    ST_LIVE = 1'b1
  } out_state_e;

  function automatic logic fell(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction

  function automatic logic rose(input logic prev, input logic cur);
    return ~prev & cur;
  endfunction

  // converter drive is offset binary; twos-complement codes flip the msb
  function automatic code_t drive_code(input code_t code, input logic twos);
    return twos ? (code ^ CODE_MSB) : code;
  endfunction

endpackage

/* verilog/dac_serial_load_control.sv */
// serial load front end of the converter: pins in, output code out
`timescale 1ns/1ps
module dac_serial_load_control (
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // serial link pins
  input wire logic sclk_i,
  input wire logic frame_n_i,
  input wire logic serial_in_i,
  // control pins
  input wire logic load_output_n_i,
  input wire logic clear_to_preset_n_i,
  input wire logic reset_n_i,
  // configuration from surrounding logic
  input wire dac_load_pkg::code_t preset_code_i,
  input wire logic twos_comp_i,
  // converter side
  output dac_load_pkg::code_t dac_code_o,
  output dac_load_pkg::code_t dac_drive_o,
  output logic clamp_o,
  output logic update_pending_o,
  output logic buffer_full_o
);
  import dac_load_pkg::*;

  // two-stage synchronisers; stage one is read only by stage two
  link_pins_s link_s1_reg, link_s2_reg;
  ctrl_pins_s ctrl_s1_reg, ctrl_s2_reg;
  logic load_d_reg, load_d_next;

  out_state_e state_reg, state_next;
  code_t input_reg, input_next;
  code_t dac_reg, dac_next;
  code_t drive_reg, drive_next;
  logic clamp_reg, clamp_next;
  logic pending_reg, pending_next;
  logic full_reg, full_next;

  logic srst_n;
  logic word_valid, word_ready;
  frame_t word;
  logic buf_valid, buf_ready;
  frame_t buf_word;
  logic load_fall, pop, update;

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      link_s1_reg <= '{sclk: 1'b0, frame_n: 1'b1, data: 1'b0};
      link_s2_reg <= '{sclk: 1'b0, frame_n: 1'b1, data: 1'b0};
      ctrl_s1_reg <= '1;
      ctrl_s2_reg <= '1;
    end else begin
      link_s1_reg <= '{sclk: sclk_i, frame_n: frame_n_i, data: serial_in_i};
      link_s2_reg <= link_s1_reg;
      ctrl_s1_reg <= '{load_output_n: load_output_n_i,
                       clear_to_preset_n: clear_to_preset_n_i,
                       reset_n: reset_n_i};
      ctrl_s2_reg <= ctrl_s1_reg;
    end
  end

  // reset pin acts like the system reset on everything behind the synchronisers
  assign srst_n = resetn_i & ctrl_s2_reg.reset_n;

  frame_shifter u_shifter (
    .clock_i(clock_i),
    .srst_n_i(srst_n),
    .pins_i(link_s2_reg),
    .word_valid_o(word_valid),
    .word_o(word),
    .word_ready_i(word_ready)
  );

  word_buffer #(
    .WIDTH(FRAME_BITS),
    .DEPTH(BUF_DEPTH)
  ) u_buffer (
    .clock_i(clock_i),
    .srst_n_i(srst_n),
    .in_valid_i(word_valid),
    .in_data_i(word),
    .in_ready_o(word_ready),
    .out_valid_o(buf_valid),
    .out_data_o(buf_word),
    .out_ready_i(buf_ready)
  );

  // a held clear stalls the drain so frames sent meanwhile wait in the buffer
  assign buf_ready = ctrl_s2_reg.clear_to_preset_n;
  assign pop = buf_valid & buf_ready;
  assign load_fall = fell(load_d_reg, ctrl_s2_reg.load_output_n);

  always_comb begin
    load_d_next = ctrl_s2_reg.load_output_n;
    input_next = input_reg;
    dac_next = dac_reg;
    pending_next = pending_reg;
    update = 1'b0;
    if (!ctrl_s2_reg.clear_to_preset_n) begin
      dac_next = preset_code_i;
      pending_next = 1'b0;
      update = 1'b1;
    end else if (pop) begin
      input_next = buf_word[CODE_BITS-1:0];
      if (!ctrl_s2_reg.load_output_n) begin
        dac_next = buf_word[CODE_BITS-1:0];
        pending_next = 1'b0;
        update = 1'b1;
      end else begin
        pending_next = 1'b1;
      end
    end else if (load_fall && pending_reg) begin
      dac_next = input_reg;
      pending_next = 1'b0;
      update = 1'b1;
    end
    drive_next = drive_code(dac_next, twos_comp_i);
    full_next = ~word_ready;
  end

  always_comb begin
    case (state_reg)
      ST_CLAMPED: state_next = update ? ST_LIVE : ST_CLAMPED;
      ST_LIVE: state_next = ST_LIVE;
      default: state_next = ST_CLAMPED;
    endcase
    clamp_next = (state_next == ST_CLAMPED);
  end

  always_ff @(posedge clock_i) begin
    if (!srst_n) begin
      load_d_reg <= 1'b1;
      input_reg <= CODE_RESET;
      dac_reg <= CODE_RESET;
      drive_reg <= CODE_RESET;
      pending_reg <= 1'b0;
      full_reg <= 1'b0;
      state_reg <= ST_CLAMPED;
      clamp_reg <= 1'b1;
    end else begin
      load_d_reg <= load_d_next;
      input_reg <= input_next;
      dac_reg <= dac_next;
      drive_reg <= drive_next;
      pending_reg <= pending_next;
      full_reg <= full_next;
      state_reg <= state_next;
      clamp_reg <= clamp_next;
    end
  end

  assign dac_code_o = dac_reg;
  assign dac_drive_o = drive_reg;
  assign clamp_o = clamp_reg;
  assign update_pending_o = pending_reg;
  assign buffer_full_o = full_reg;

  property p_reset_pin;
    @(posedge clock_i) disable iff (!resetn_i)
      !ctrl_s2_reg.reset_n |=> clamp_o && dac_code_o == CODE_RESET && !update_pending_o;
  endproperty
  a_reset_pin: assert property (p_reset_pin)
    else $error("reset pin did not restore the power-up state");

  property p_clear_loads_preset;
    @(posedge clock_i) disable iff (!srst_n)
      !ctrl_s2_reg.clear_to_preset_n |=> dac_code_o == $past(preset_code_i) && !clamp_o;
  endproperty
  a_clear_loads_preset: assert property (p_clear_loads_preset)
    else $error("clear did not load the preset code");

  property p_clear_coding;
    @(posedge clock_i) disable iff (!srst_n)
      !ctrl_s2_reg.clear_to_preset_n ##1 !ctrl_s2_reg.clear_to_preset_n
        |-> dac_drive_o == ($past(twos_comp_i) ? (dac_code_o ^ CODE_MSB) : dac_code_o);
  endproperty
  a_clear_coding: assert property (p_clear_coding)
    else $error("drive code ignores the selected coding");

  property p_load_low_updates;
    @(posedge clock_i) disable iff (!srst_n)
      (pop && !ctrl_s2_reg.load_output_n)
        |=> dac_code_o == $past(buf_word[CODE_BITS-1:0]) && !update_pending_o;
  endproperty
  a_load_low_updates: assert property (p_load_low_updates)
    else $error("frame end with load low did not update the output");

  property p_load_high_holds;
    @(posedge clock_i) disable iff (!srst_n)
      (pop && ctrl_s2_reg.load_output_n)
        |=> $stable(dac_code_o) && update_pending_o;
  endproperty
  a_load_high_holds: assert property (p_load_high_holds)
    else $error("output changed although load was high");

  property p_load_fall_applies;
    @(posedge clock_i) disable iff (!srst_n)
      (load_fall && pending_reg && !pop && ctrl_s2_reg.clear_to_preset_n)
        |=> dac_code_o == $past(input_reg) && !update_pending_o;
  endproperty
  a_load_fall_applies: assert property (p_load_fall_applies)
    else $error("falling load did not apply the held word");

  property p_clamp_held;
    @(posedge clock_i) disable iff (!srst_n)
      (clamp_o && !update) |=> clamp_o && dac_code_o == CODE_RESET;
  endproperty
  a_clamp_held: assert property (p_clamp_held)
    else $error("clamp released without an update");

  property p_frame_reaches_output;
    @(posedge clock_i) disable iff (!srst_n)
      (word_valid && word_ready && !buf_valid && !ctrl_s2_reg.load_output_n
        && ctrl_s2_reg.clear_to_preset_n)
        ##1 (!ctrl_s2_reg.load_output_n && ctrl_s2_reg.clear_to_preset_n)
        |=> dac_code_o == $past(word[CODE_BITS-1:0], 2);
  endproperty
  a_frame_reaches_output: assert property (p_frame_reaches_output)
    else $error("received word did not reach the converter register");

  property p_sync_link;
    @(posedge clock_i) disable iff (!resetn_i)
      1'b1 |=> link_s2_reg == $past(link_s1_reg);
  endproperty
  a_sync_link: assert property (p_sync_link)
    else $error("link pins skipped a synchroniser stage");

  property p_reset_pin_drive;
    @(posedge clock_i) disable iff (!resetn_i)
      !ctrl_s2_reg.reset_n |=> dac_drive_o == CODE_RESET && !buffer_full_o;
  endproperty
  a_reset_pin_drive: assert property (p_reset_pin_drive)
    else $error("reset pin left the drive code or full flag set");

  property p_drive_coding;
    @(posedge clock_i) disable iff (!srst_n)
      $past(srst_n)
        |-> dac_drive_o == ($past(twos_comp_i) ? (dac_code_o ^ CODE_MSB) : dac_code_o);
  endproperty
  a_drive_coding: assert property (p_drive_coding)
    else $error("drive code does not follow the selected coding");

  property p_clear_freezes_input;
    @(posedge clock_i) disable iff (!srst_n)
      !ctrl_s2_reg.clear_to_preset_n
        |=> !update_pending_o && $stable(input_reg);
  endproperty
  a_clear_freezes_input: assert property (p_clear_freezes_input)
    else $error("held word survived a clear");

  property p_no_update_keeps_code;
    @(posedge clock_i) disable iff (!srst_n)
      !update |=> $stable(dac_code_o);
  endproperty
  a_no_update_keeps_code: assert property (p_no_update_keeps_code)
    else $error("converter code changed without an update");

  property p_pending_source;
    @(posedge clock_i) disable iff (!srst_n)
      !update_pending_o ##1 update_pending_o
        |-> $past(pop) && $past(ctrl_s2_reg.load_output_n);
  endproperty
  a_pending_source: assert property (p_pending_source)
    else $error("pending flag set without a held frame");

  property p_input_capture;
    @(posedge clock_i) disable iff (!srst_n)
      pop |=> input_reg == $past(buf_word[CODE_BITS-1:0]);
  endproperty
  a_input_capture: assert property (p_input_capture)
    else $error("input register missed a received word");

  property p_load_fall_idle;
    @(posedge clock_i) disable iff (!srst_n)
      (load_fall && !pending_reg && !pop && ctrl_s2_reg.clear_to_preset_n)
        |=> $stable(dac_code_o);
  endproperty
  a_load_fall_idle: assert property (p_load_fall_idle)
    else $error("load fall with nothing held changed the output");

  property p_update_releases_clamp;
    @(posedge clock_i) disable iff (!srst_n)
      update |=> !clamp_o;
  endproperty
  a_update_releases_clamp: assert property (p_update_releases_clamp)
    else $error("clamp stayed on after an output update");

  property p_live_stays;
    @(posedge clock_i) disable iff (!srst_n)
      !clamp_o |=> !clamp_o;
  endproperty
  a_live_stays: assert property (p_live_stays)
    else $error("clamp came back without a reset");

  property p_clamped_code_zero;
    @(posedge clock_i) disable iff (!srst_n)
      clamp_o |-> dac_code_o == CODE_RESET;
  endproperty
  a_clamped_code_zero: assert property (p_clamped_code_zero)
    else $error("clamped output holds a nonzero code");

  property p_state_clamp;
    @(posedge clock_i) disable iff (!srst_n)
      1'b1 |-> clamp_o == (state_reg == ST_CLAMPED);
  endproperty
  a_state_clamp: assert property (p_state_clamp)
    else $error("clamp output disagrees with the output state");

  property p_full_flag;
    @(posedge clock_i) disable iff (!srst_n)
      $past(srst_n)
        |-> buffer_full_o == !$past(word_ready);
  endproperty
  a_full_flag: assert property (p_full_flag)
    else $error("full flag does not follow the buffer");

endmodule // dac_serial_load_control

/* verilog/frame_shifter.sv */
// serial frame receiver: samples the link pins, assembles 24-bit words
`timescale 1ns/1ps
module frame_shifter (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_n_i,
  // synchronised link pins
  input wire dac_load_pkg::link_pins_s pins_i,
  // received word stream
  output logic word_valid_o,
  output dac_load_pkg::frame_t word_o,
  input wire logic word_ready_i
);
  import dac_load_pkg::*;

  logic sclk_d_reg, sclk_d_next;
  logic frame_d_reg, frame_d_next;
  frame_t shift_reg, shift_next;
  logic [COUNT_BITS-1:0] count_reg, count_next;
  logic valid_reg, valid_next;
  frame_t word_reg, word_next;
  logic sclk_fall;
  logic frame_rise;

  assign sclk_fall = fell(sclk_d_reg, pins_i.sclk) & ~pins_i.frame_n;
  assign frame_rise = rose(frame_d_reg, pins_i.frame_n);

  always_comb begin
    sclk_d_next = pins_i.sclk;
    frame_d_next = pins_i.frame_n;
    shift_next = shift_reg;
    count_next = count_reg;
    valid_next = valid_reg & ~word_ready_i;
    word_next = word_reg;
    if (sclk_fall) begin
      shift_next = {shift_reg[FRAME_BITS-2:0], pins_i.data};
      if (count_reg != COUNT_MAX) begin
        count_next = count_reg + 5'h01;
      end
    end
    if (frame_rise) begin
      count_next = 5'h00;
      // short or long frames are dropped; a word still unclaimed is kept
      if (count_reg == COUNT_FULL && !valid_next) begin
        valid_next = 1'b1;
        word_next = shift_reg;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!srst_n_i) begin
      sclk_d_reg <= 1'b0;
      frame_d_reg <= 1'b1;
      shift_reg <= '0;
      count_reg <= 5'h00;
      valid_reg <= 1'b0;
      word_reg <= '0;
    end else begin
      sclk_d_reg <= sclk_d_next;
      frame_d_reg <= frame_d_next;
      shift_reg <= shift_next;
      count_reg <= count_next;
      valid_reg <= valid_next;
      word_reg <= word_next;
    end
  end

  assign word_valid_o = valid_reg;
  assign word_o = word_reg;

  property p_shift_on_fall;
    @(posedge clock_i) disable iff (!srst_n_i)
      sclk_fall |=> shift_reg == {$past(shift_reg[FRAME_BITS-2:0]), $past(pins_i.data)};
  endproperty
  a_shift_on_fall: assert property (p_shift_on_fall)
    else $error("shift register missed a falling serial clock");

  property p_idle_when_deselected;
    @(posedge clock_i) disable iff (!srst_n_i)
      pins_i.frame_n |=> $stable(shift_reg);
  endproperty
  a_idle_when_deselected: assert property (p_idle_when_deselected)
    else $error("shift register moved while frame select was high");

  property p_word_at_frame_end;
    @(posedge clock_i) disable iff (!srst_n_i)
      (frame_rise && count_reg == COUNT_FULL && !valid_reg)
        |=> valid_reg && word_reg == $past(shift_reg);
  endproperty
  a_word_at_frame_end: assert property (p_word_at_frame_end)
    else $error("complete frame was not handed on");

endmodule // frame_shifter

/* verilog/word_buffer.sv */
// two-entry word buffer with valid and ready on both sides
`timescale 1ns/1ps
module word_buffer #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_n_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH], mem_next [DEPTH];
  logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic push, pop;

  assign in_ready_o = cnt_reg != FULL;
  assign out_valid_o = cnt_reg != '0;
  assign out_data_o = mem_reg[rd_reg];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_comb begin
    mem_next = mem_reg;
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    if (push) begin
      mem_next[wr_reg] = in_data_i;
      wr_next = (wr_reg == LAST) ? '0 : wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = (rd_reg == LAST) ? '0 : rd_reg + 1'b1;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!srst_n_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
    mem_reg <= mem_next;
  end

endmodule // word_buffer
